//--- hw/lva_regs_map.svh
// Offsets, field positions and reset values of the LDO A-setting bank.
// Assumes a 32-bit AHB-Lite slave; byte addresses are index times four.
// ============================================================
`ifndef LVA_REGS_MAP_SVH
`define LVA_REGS_MAP_SVH
`define LVA_IDX_EIGHT      8'hb0
`define LVA_IDX_NINE       8'hb1
`define LVA_IDX_RSVD       8'hb2
`define LVA_SL_BIT         7
`define LVA_RSVD_BIT       6
`define LVA_CODE_MSB       5
`define LVA_RST_BYTE       8'h00
`define LVA_E_FLOOR_CODE   6'h02
`define LVA_E_FLOOR_MV     16'h0384
`define LVA_N_FLOOR_CODE   6'h03
`define LVA_N_FLOOR_MV     16'h03b6
`define LVA_N_TOP_CODE     6'h38
`define LVA_N_TOP_MV       16'h0e10
`define LVA_STEP_MV        16'h0032
`endif

//--- hw/lva_pkg.sv
// Types shared by the LDO A-setting bank.
// Assumes the map header is compiled alongside.
`default_nettype none
package lva_pkg;
  typedef enum logic [1:0] {
    LVA_HALF_CURRENT = 2'b00,
    LVA_SLEEP        = 2'b01
  } lva_lp_mode_t;
  typedef logic [5:0] lva_code_t;
endpackage
`default_nettype wire

//--- hw/lva_decode.sv
// Converts a 6-bit voltage code to a millivolt target.
// Assumes floor, step and optional ceiling from the caller.
`timescale 1ns/1ps
`default_nettype none
module lva_decode #(
  parameter logic [5:0]  FLOOR_CODE = 6'h02,
  parameter logic [15:0] FLOOR_MV   = 16'h0384,
  parameter logic [15:0] STEP_MV    = 16'h0032,
  parameter logic        HAS_TOP    = 1'b0,
  parameter logic [5:0]  TOP_CODE   = 6'h3f,
  parameter logic [15:0] TOP_MV     = 16'h0e10,
  parameter logic        ZERO_VOID  = 1'b0
) (
  input  wire logic [5:0]  i_code,
  output logic      [15:0] o_mv,
  output logic             o_valid
);
  logic [15:0] steps;
  always_comb begin
    steps = 16'h0000;
    if (i_code > FLOOR_CODE) begin
      steps = 16'(i_code - FLOOR_CODE);
    end
    o_mv    = 16'(FLOOR_MV + 16'(steps * STEP_MV));
    o_valid = 1'b1;
    if (HAS_TOP && (i_code >= TOP_CODE)) begin
      o_mv = TOP_MV;
    end
    if (ZERO_VOID && (i_code == 6'h00)) begin
      o_valid = 1'b0;
      o_mv    = 16'h0000;
    end
  end
endmodule
`default_nettype wire

//--- hw/lva_regs.sv
// AHB-Lite register bank with A-setting bytes of two LDOs.
// Assumes a single master, word transfers, zero-wait answers.
//
// Added by the designer: the AHB-Lite slave port.
`include "lva_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lva_regs (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_hsel,
  input  wire logic [31:0]  i_haddr,
  input  wire logic [1:0]   i_htrans,
  input  wire logic         i_hwrite,
  input  wire logic [2:0]   i_hsize,
  input  wire logic [31:0]  i_hwdata,
  input  wire logic         i_hready,
  output logic      [31:0]  o_hrdata,
  output logic              o_hreadyout,
  output logic              o_hresp,
  output lva_pkg::lva_lp_mode_t o_eight_lp_mode,
  output lva_pkg::lva_code_t    o_eight_code,
  output logic      [15:0]  o_eight_mv,
  output lva_pkg::lva_lp_mode_t o_nine_lp_mode,
  output lva_pkg::lva_code_t    o_nine_code,
  output logic      [15:0]  o_nine_mv,
  output logic              o_nine_code_valid
);
  import lva_pkg::*;
  // ============================================================
  // Address phase capture
  logic        wr_pend_r;
  logic [7:0]  wr_idx_r;
  logic [7:0]  ldo_eight_a_setting_r;
  logic [7:0]  ldo_nine_a_setting_r;
  logic [7:0]  a_idx;
  logic        take;
  assign a_idx = i_haddr[9:2];
  assign take  = i_hsel && i_hready && i_htrans[1];
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end else begin
      wr_pend_r <= take && i_hwrite;
      wr_idx_r  <= a_idx;
    end
  end
  // ============================================================
  // Storage; reserved bit 6 stored as written
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ldo_eight_a_setting_r <= `LVA_RST_BYTE;
      ldo_nine_a_setting_r  <= `LVA_RST_BYTE;
    end else if (wr_pend_r) begin
      if (wr_idx_r == `LVA_IDX_EIGHT) begin
        ldo_eight_a_setting_r <= i_hwdata[7:0];
      end
      if (wr_idx_r == `LVA_IDX_NINE) begin
        ldo_nine_a_setting_r <= i_hwdata[7:0];
      end
    end
  end
  // ============================================================
  // Read data, registered at address phase; unmapped reads zero
  // Write in its data phase is forwarded, so a pipelined read sees it
  logic [7:0]  eight_view;
  logic [7:0]  nine_view;
  assign eight_view = (wr_pend_r && (wr_idx_r == `LVA_IDX_EIGHT)) ? i_hwdata[7:0] : ldo_eight_a_setting_r;
  assign nine_view  = (wr_pend_r && (wr_idx_r == `LVA_IDX_NINE)) ? i_hwdata[7:0] : ldo_nine_a_setting_r;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (take && !i_hwrite) begin
      case (a_idx)
        `LVA_IDX_EIGHT: o_hrdata <= {24'h000000, eight_view};
        `LVA_IDX_NINE:  o_hrdata <= {24'h000000, nine_view};
        default:        o_hrdata <= 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end
  // ============================================================
  // Mode and code decode
  logic [15:0] e_mv;
  logic [15:0] n_mv;
  logic        n_ok;
  lva_decode #(
    .FLOOR_CODE (`LVA_E_FLOOR_CODE),
    .FLOOR_MV   (`LVA_E_FLOOR_MV),
    .STEP_MV    (`LVA_STEP_MV),
    .HAS_TOP    (1'b0),
    .TOP_CODE   (6'h3f),
    .TOP_MV     (16'h0000),
    .ZERO_VOID  (1'b0)
  ) u_dec_eight (
    .i_code  (ldo_eight_a_setting_r[`LVA_CODE_MSB:0]),
    .o_mv    (e_mv),
    .o_valid ()
  );
  lva_decode #(
    .FLOOR_CODE (`LVA_N_FLOOR_CODE),
    .FLOOR_MV   (`LVA_N_FLOOR_MV),
    .STEP_MV    (`LVA_STEP_MV),
    .HAS_TOP    (1'b1),
    .TOP_CODE   (`LVA_N_TOP_CODE),
    .TOP_MV     (`LVA_N_TOP_MV),
    .ZERO_VOID  (1'b1)
  ) u_dec_nine (
    .i_code  (ldo_nine_a_setting_r[`LVA_CODE_MSB:0]),
    .o_mv    (n_mv),
    .o_valid (n_ok)
  );
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_eight_lp_mode   <= LVA_HALF_CURRENT;
      o_nine_lp_mode    <= LVA_HALF_CURRENT;
      o_eight_code      <= 6'h00;
      o_nine_code       <= 6'h00;
      o_eight_mv        <= `LVA_E_FLOOR_MV;
      o_nine_mv         <= 16'h0000;
      o_nine_code_valid <= 1'b0;
    end else begin
      o_eight_lp_mode   <= ldo_eight_a_setting_r[`LVA_SL_BIT] ? LVA_SLEEP : LVA_HALF_CURRENT;
      o_nine_lp_mode    <= ldo_nine_a_setting_r[`LVA_SL_BIT] ? LVA_SLEEP : LVA_HALF_CURRENT;
      o_eight_code      <= ldo_eight_a_setting_r[`LVA_CODE_MSB:0];
      o_nine_code       <= ldo_nine_a_setting_r[`LVA_CODE_MSB:0];
      o_eight_mv        <= e_mv;
      o_nine_mv         <= n_mv;
      o_nine_code_valid <= n_ok;
    end
  end
  // ============================================================
  // Checks
  sequence s_wr_eight;
    take && i_hwrite && (a_idx == `LVA_IDX_EIGHT);
  endsequence
  property p_eight_sleep;
    @(posedge i_clk) disable iff (!i_arst_n)
      ##1 1 |-> (o_eight_lp_mode == LVA_SLEEP) == $past(ldo_eight_a_setting_r[7]);
  endproperty
  a_eight_sleep: assert property (p_eight_sleep) else $error("eight mode wrong");
  property p_nine_sleep;
    @(posedge i_clk) disable iff (!i_arst_n)
      ##1 1 |-> (o_nine_lp_mode == LVA_SLEEP) == $past(ldo_nine_a_setting_r[7]);
  endproperty
  a_nine_sleep: assert property (p_nine_sleep) else $error("nine mode wrong");
  property p_eight_floor;
    @(posedge i_clk) disable iff (!i_arst_n)
      (ldo_eight_a_setting_r[5:0] <= 6'h02) |=> (o_eight_mv == 16'h0384);
  endproperty
  a_eight_floor: assert property (p_eight_floor) else $error("eight floor wrong");
  property p_eight_step;
    @(posedge i_clk) disable iff (!i_arst_n)
      (ldo_eight_a_setting_r[5:0] == 6'h22) |=> (o_eight_mv == 16'h09c4);
  endproperty
  a_eight_step: assert property (p_eight_step) else $error("eight 2.50 V wrong");
  property p_nine_void;
    @(posedge i_clk) disable iff (!i_arst_n)
      (ldo_nine_a_setting_r[5:0] == 6'h00) |=> !o_nine_code_valid;
  endproperty
  a_nine_void: assert property (p_nine_void) else $error("nine zero not void");
  property p_nine_low;
    @(posedge i_clk) disable iff (!i_arst_n)
      (ldo_nine_a_setting_r[5:0] == 6'h01) |=> o_nine_code_valid && (o_nine_mv == 16'h03b6);
  endproperty
  a_nine_low: assert property (p_nine_low) else $error("nine low wrong");
  property p_nine_top;
    @(posedge i_clk) disable iff (!i_arst_n)
      (ldo_nine_a_setting_r[5:0] >= 6'h38) |=> (o_nine_mv == 16'h0e10);
  endproperty
  a_nine_top: assert property (p_nine_top) else $error("nine top wrong");
  property p_wr_lands;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_wr_eight ##1 1 |=> (ldo_eight_a_setting_r == $past(i_hwdata[7:0]));
  endproperty
  a_wr_lands: assert property (p_wr_lands) else $error("write lost");
  sequence s_rd_eight;
    take && !i_hwrite && (a_idx == `LVA_IDX_EIGHT);
  endsequence
  sequence s_rd_nine;
    take && !i_hwrite && (a_idx == `LVA_IDX_NINE);
  endsequence
  property p_rd_eight;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_rd_eight |=> (o_hrdata == {24'h000000, $past(eight_view)});
  endproperty
  a_rd_eight: assert property (p_rd_eight) else $error("eight read wrong");
  property p_rd_nine;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_rd_nine |=> (o_hrdata == {24'h000000, $past(nine_view)});
  endproperty
  a_rd_nine: assert property (p_rd_nine) else $error("nine read wrong");
  property p_eight_code;
    @(posedge i_clk) disable iff (!i_arst_n)
      ##1 1 |-> (o_eight_code == $past(ldo_eight_a_setting_r[5:0]));
  endproperty
  a_eight_code: assert property (p_eight_code) else $error("eight code wrong");
  property p_nine_code;
    @(posedge i_clk) disable iff (!i_arst_n)
      ##1 1 |-> (o_nine_code == $past(ldo_nine_a_setting_r[5:0]));
  endproperty
  a_nine_code: assert property (p_nine_code) else $error("nine code wrong");
  property p_nine_step;
    @(posedge i_clk) disable iff (!i_arst_n)
      (ldo_nine_a_setting_r[5:0] == 6'h22) |=> (o_nine_mv == 16'h09c4);
  endproperty
  a_nine_step: assert property (p_nine_step) else $error("nine 2.50 V wrong");
  property p_nine_edge;
    @(posedge i_clk) disable iff (!i_arst_n)
      (ldo_nine_a_setting_r[5:0] == 6'h37) |=> (o_nine_mv == 16'h0dde);
  endproperty
  a_nine_edge: assert property (p_nine_edge) else $error("nine 3.55 V wrong");
endmodule
`default_nettype wire

//--- bench/lva_regs_tb.sv
// Self-checking bench for the LDO A-setting register bank.
// Assumes one AHB-Lite master (this bench) and the bank as the only slave.
`timescale 1ns/1ps
`default_nettype none
module lva_regs_tb;
  import lva_pkg::*;
  logic         clk, arst_n, hsel, hwrite, hready, hresp, n_valid;
  logic  [31:0] haddr, hwdata, hrdata, rd;
  logic  [1:0]  htrans;
  logic  [2:0]  hsize;
  lva_lp_mode_t e_mode, n_mode;
  lva_code_t    e_code, n_code;
  logic  [15:0] e_mv, n_mv;
  int           n_errors, checked;
  localparam logic [6:0][7:0] T_E = {8'hb8, 8'h23, 8'ha2, 8'h83, 8'h02, 8'h81, 8'h00};
  localparam logic [6:0][7:0] T_N = {8'h22, 8'hbf, 8'h38, 8'hb7, 8'h02, 8'h01, 8'h80};

  lva_regs DUT (
    .i_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .o_eight_lp_mode(e_mode), .o_eight_code(e_code), .o_eight_mv(e_mv),
    .o_nine_lp_mode(n_mode), .o_nine_code(n_code), .o_nine_mv(n_mv), .o_nine_code_valid(n_valid)
  );

  // ============================================================
  // Helpers
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask

  // One single word transfer; waits on hready, no fixed latency assumed
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    haddr  <= a;
    hwrite <= w;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  function automatic logic [15:0] x_eight(input logic [5:0] c);
    return (c <= 6'h02) ? 16'h0384 : 16'h0384 + 16'h0032 * 16'(c - 6'h02);
  endfunction

  // Code 0 unused, floor runs up to code 3, saturates from 0x38
  function automatic logic [15:0] x_nine(input logic [5:0] c);
    if (c == 6'h00) return 16'h0000;
    if (c <= 6'h03) return 16'h03b6;
    if (c >= 6'h38) return 16'h0e10;
    return 16'h03b6 + 16'h0032 * 16'(c - 6'h03);
  endfunction

  // Outputs settle one edge after the data phase; checked after two edges
  task automatic check_out(input logic [7:0] e, input logic [7:0] n);
    repeat (2) @(posedge clk);
    chk("eight_mode", 32'(e[7] ? LVA_SLEEP : LVA_HALF_CURRENT), 32'(e_mode));
    chk("eight_code", 32'(e[5:0]), 32'(e_code));
    chk("eight_mv", 32'(x_eight(e[5:0])), 32'(e_mv));
    chk("nine_mode", 32'(n[7] ? LVA_SLEEP : LVA_HALF_CURRENT), 32'(n_mode));
    chk("nine_code", 32'(n[5:0]), 32'(n_code));
    chk("nine_mv", 32'(x_nine(n[5:0])), 32'(n_mv));
    chk("nine_valid", 32'(n[5:0] != 6'h00), 32'(n_valid));
  endtask

  // ============================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  // ============================================================
  // Tests
  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    n_errors = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check_out(8'h00, 8'h00);
    for (int i = 0; i < 7; i++) begin
      bus(32'h2c0, 1'b1, {24'h0, T_E[i]});
      bus(32'h2c4, 1'b1, {24'h0, T_N[i]});
      check_out(T_E[i], T_N[i]);
      bus(32'h2c0, 1'b0, 32'h0);
      chk("eight_byte", {24'h0, T_E[i]}, rd);
      bus(32'h2c4, 1'b0, 32'h0);
      chk("nine_byte", {24'h0, T_N[i]}, rd);
    end
    // Unmapped place ignores writes and reads zero
    bus(32'h0000_0000, 1'b1, 32'h0000_00ff);
    bus(32'h0000_0000, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(32'h2c8, 1'b1, 32'h0);
    bus(32'h2c8, 1'b0, 32'h0);
    chk("reserved_byte", 32'h0, rd);
    chk("reserved_resp", 32'h0, 32'(hresp));
    check_out(T_E[6], T_N[6]);
    // Second reset in mid-run clears the stored bytes
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(32'h2c0, 1'b0, 32'h0);
    chk("eight_after_reset", 32'h0, rd);
    bus(32'h2c4, 1'b0, 32'h0);
    chk("nine_after_reset", 32'h0, rd);
    check_out(8'h00, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
